/* odmx_regs.sv */
// Open-detect flags, diagnostic source selectors and their APB slave.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module odmx_regs (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end status.
  input  wire logic        conv_done,
  input  wire logic [7:0]  code_unchanged,
  input  wire logic [7:0]  open_detect_event,
  // Analog front end control.
  output logic      [7:0]  cm_switch,
  output logic      [7:0]  pga_cm_high,
  output logic [5:0][7:0]  chan_source_route,
  output logic      [5:0]  range_10v,
  // Interrupt.
  output logic             irq
);
  import odmx_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------

  // True when the byte address names a register of this block.
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == byte_addr(IDX_OPEN_ENABLE)) ||
                  (addr == byte_addr(IDX_OPEN_FLAGS))  ||
                  (addr == byte_addr(IDX_SEL_CH1_CH2)) ||
                  (addr == byte_addr(IDX_SEL_CH3_CH4)) ||
                  (addr == byte_addr(IDX_SEL_CH5_CH6)) ||
                  (addr == byte_addr(IDX_OPEN_QUEUE))  ||
                  (addr == byte_addr(IDX_IRQ_MASK));
  endfunction

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [7:0]                 open_flags_reg;
  logic [7:0]                 open_flags_next;
  logic [7:0]                 open_enable_reg;
  logic [7:0]                 open_enable_next;
  logic [7:0]                 open_queue_reg;
  logic [7:0]                 open_queue_next;
  logic [7:0]                 irq_mask_reg;
  logic [7:0]                 irq_mask_next;
  logic [NUM_SEL_REGS-1:0][5:0] sel_reg;
  logic [NUM_SEL_REGS-1:0][5:0] sel_next;
  logic                       pready_reg;
  logic                       pready_next;
  logic                       pslverr_reg;
  logic                       pslverr_next;
  logic [31:0]                prdata_reg;
  logic [31:0]                prdata_next;
  logic                       irq_reg;
  logic                       irq_next;
  logic [7:0]                 pga_cm_reg;
  logic [7:0]                 pga_cm_next;

  logic                       apb_access;
  logic                       apb_commit;
  logic                       wr_commit;
  logic                       auto_mode;
  logic                       manual_mode;
  logic [7:0]                 flag_set;
  logic [7:0]                 flag_clear;
  logic [7:0]                 wr_byte;
  logic [31:0]                read_value;

  // ----------------------------------------------------------------------
  // Bus phases and detection qualifiers.
  // ----------------------------------------------------------------------

  // One wait state: the access phase ends on the second cycle.
  assign apb_access  = psel && penable;
  assign apb_commit  = apb_access && pready_reg;
  assign wr_commit   = apb_commit && pwrite && addr_mapped(paddr);
  assign wr_byte     = pwdata[7:0];
  assign auto_mode   = (open_queue_reg >= AUTO_QUEUE_MIN);
  assign manual_mode = (open_queue_reg == MANUAL_QUEUE);

  // Only enabled channels in automatic mode may raise a flag.
  assign flag_set = open_detect_event & open_enable_reg
                  & {8{auto_mode}};
  assign flag_clear = (wr_commit && paddr == byte_addr(IDX_OPEN_FLAGS))
                    ? wr_byte : 8'h00;

  // Read multiplexer; narrow registers sit in the low bits.
  always_comb begin
    read_value = 32'h0000_0000;
    case (paddr)
      byte_addr(IDX_OPEN_ENABLE): read_value[7:0] = open_enable_reg;
      byte_addr(IDX_OPEN_FLAGS):  read_value[7:0] = open_flags_reg;
      byte_addr(IDX_SEL_CH1_CH2): read_value[5:0] = sel_reg[0];
      byte_addr(IDX_SEL_CH3_CH4): read_value[5:0] = sel_reg[1];
      byte_addr(IDX_SEL_CH5_CH6): read_value[5:0] = sel_reg[2];
      byte_addr(IDX_OPEN_QUEUE):  read_value[7:0] = open_queue_reg;
      byte_addr(IDX_IRQ_MASK):    read_value[7:0] = irq_mask_reg;
      default:                    read_value      = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register bank next state.
  // ----------------------------------------------------------------------

  // Writes land at the edge where pready is sampled high.
  always_comb begin
    open_enable_next = open_enable_reg;
    open_queue_next  = open_queue_reg;
    irq_mask_next    = irq_mask_reg;
    sel_next         = sel_reg;
    if (wr_commit) begin
      case (paddr)
        byte_addr(IDX_OPEN_ENABLE): open_enable_next = wr_byte;
        byte_addr(IDX_SEL_CH1_CH2): sel_next[0] = wr_byte[5:0];
        byte_addr(IDX_SEL_CH3_CH4): sel_next[1] = wr_byte[5:0];
        byte_addr(IDX_SEL_CH5_CH6): sel_next[2] = wr_byte[5:0];
        byte_addr(IDX_OPEN_QUEUE):  open_queue_next = wr_byte;
        byte_addr(IDX_IRQ_MASK):    irq_mask_next = wr_byte;
        default:                    open_queue_next = open_queue_reg;
      endcase
    end
    // A detection in the clearing cycle survives the clear.
    open_flags_next = (open_flags_reg & ~flag_clear) | flag_set;
    // Manual mode lets the enable bits raise the common mode directly.
    pga_cm_next = manual_mode ? open_enable_next : 8'h00;
    irq_next    = |(open_flags_next & irq_mask_next);
  end

  // APB answer next state.
  always_comb begin
    pready_next  = apb_access && !pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    if (apb_access && !pready_reg) begin
      prdata_next  = pwrite ? 32'h0000_0000 : read_value;
      pslverr_next = !addr_mapped(paddr);
    end else if (!apb_access) begin
      pslverr_next = 1'b0;
    end
  end

  // Registers every piece of bank and bus state.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      open_flags_reg  <= OPEN_FLAGS_RST;
      open_enable_reg <= OPEN_ENABLE_RST;
      open_queue_reg  <= OPEN_QUEUE_RST;
      irq_mask_reg    <= IRQ_MASK_RST;
      sel_reg         <= {NUM_SEL_REGS{SEL_RST}};
      pready_reg      <= 1'b0;
      pslverr_reg     <= 1'b0;
      prdata_reg      <= 32'h0000_0000;
      irq_reg         <= 1'b0;
      pga_cm_reg      <= 8'h00;
    end else begin
      open_flags_reg  <= open_flags_next;
      open_enable_reg <= open_enable_next;
      open_queue_reg  <= open_queue_next;
      irq_mask_reg    <= irq_mask_next;
      sel_reg         <= sel_next;
      pready_reg      <= pready_next;
      pslverr_reg     <= pslverr_next;
      prdata_reg      <= prdata_next;
      irq_reg         <= irq_next;
      pga_cm_reg      <= pga_cm_next;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign irq         = irq_reg;
  assign pga_cm_high = pga_cm_reg;

  // ----------------------------------------------------------------------
  // Unchanged-code run counters, one per input.
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_INPUTS; ch++) begin : g_queue
    logic [7:0] run_reg;
    logic [7:0] run_next;
    logic       cm_reg;
    logic       cm_next;

    // Counts conversions with no code change; switches at the queue count.
    always_comb begin
      run_next = run_reg;
      cm_next  = 1'b0;
      if (!auto_mode || !open_enable_reg[ch]) begin
        run_next = 8'h00;
      end else if (conv_done) begin
        if (!code_unchanged[ch]) begin
          run_next = 8'h00;
        end else if (run_reg + 8'h01 >= open_queue_reg) begin
          run_next = 8'h00;
          cm_next  = 1'b1;
        end else begin
          run_next = run_reg + 8'h01;
        end
      end
    end

    // Registers the run count and the one-cycle switch pulse.
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        run_reg <= 8'h00;
        cm_reg  <= 1'b0;
      end else begin
        run_reg <= run_next;
        cm_reg  <= cm_next;
      end
    end

    assign cm_switch[ch] = cm_reg;
  end

  // ----------------------------------------------------------------------
  // Per-channel source routing.
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NUM_SEL_CHANS; c++) begin : g_route
    localparam int unsigned LSB = (c % 2 == 1) ? EVEN_SEL_LSB : ODD_SEL_LSB;

    odmx_source_decode u_decode (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .sel_code     (sel_reg[c/2][LSB +: SEL_W]),
      .route_onehot (chan_source_route[c]),
      .range_10v    (range_10v[c])
    );
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence wr_to(logic [7:0] idx);
    psel && penable && pready && pwrite && paddr == byte_addr(idx);
  endsequence

  sequence rd_to(logic [7:0] idx);
    psel && penable && pready && !pwrite && paddr == byte_addr(idx);
  endsequence

  flags_reset_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> open_flags_reg == 8'h00)
    else $error("Open flags not clear after reset.");

  flag_w1c_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_to(IDX_OPEN_FLAGS) |=>
      ((open_flags_reg & $past(pwdata[7:0]) & ~$past(flag_set)) == 8'h00)
      && ((open_flags_reg & ~$past(pwdata[7:0]))
          == (($past(open_flags_reg) & ~$past(pwdata[7:0]))
              | ($past(flag_set) & ~$past(pwdata[7:0])))))
    else $error("Write-one-to-clear misbehaves on the open flags.");

  flag_set_gate_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> (open_flags_reg & ~$past(open_flags_reg)
              & ~($past(open_detect_event) & $past(open_enable_reg)
                  & {8{$past(open_queue_reg) > 8'h01}})) == 8'h00)
    else $error("Open flag rose without an enabled automatic detection.");

  flag_capture_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (open_detect_event[7] && open_enable_reg[7] && open_queue_reg > 8'h01)
      |=> open_flags_reg[7] ##1 open_flags_reg[7] || $past(flag_clear[7]))
    else $error("Input 8 detection not held in bit 7.");

  sel_reserved_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_to(IDX_SEL_CH1_CH2) or rd_to(IDX_SEL_CH5_CH6)
      |-> prdata[31:6] == 26'h0)
    else $error("Reserved selector bits read as nonzero.");

  sel_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_to(IDX_SEL_CH3_CH4) |=> ##1
      chan_source_route[2] == (8'h01 << $past(pwdata[2:0], 2))
      && chan_source_route[3] == (8'h01 << $past(pwdata[5:3], 2)))
    else $error("Channel 3 or 4 routing does not follow its write.");

  sel_reset_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> sel_reg == '0 ##1 chan_source_route[0] == 8'h01)
    else $error("Selectors not at the input pin after reset.");

  cm_switch_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    cm_switch[0] |-> $past(open_queue_reg) > 8'h01 && $past(conv_done)
      && $past(code_unchanged[0]) && $past(open_enable_reg[0]))
    else $error("Common mode switched outside automatic detection.");

  apb_wait_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer is not one pulse after one wait.");

endmodule

`default_nettype wire

/* odmx_pkg.sv */
// Shared constants for the open-detect flag and diagnostic source registers.
package odmx_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_OPEN_ENABLE = 8'h23;
  localparam logic [7:0] IDX_OPEN_FLAGS  = 8'h24;
  localparam logic [7:0] IDX_SEL_CH1_CH2 = 8'h28;
  localparam logic [7:0] IDX_SEL_CH3_CH4 = 8'h29;
  localparam logic [7:0] IDX_SEL_CH5_CH6 = 8'h2A;
  localparam logic [7:0] IDX_OPEN_QUEUE  = 8'h2C;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h30;

  // ----------------------------------------------------------------------
  // Sizes and field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_INPUTS    = 8;
  localparam int unsigned NUM_SEL_REGS  = 3;
  localparam int unsigned NUM_SEL_CHANS = 6;
  localparam int unsigned SEL_W         = 3;
  localparam int unsigned SEL_FIELDS_W  = 6;
  localparam int unsigned ODD_SEL_LSB   = 0;
  localparam int unsigned EVEN_SEL_LSB  = 3;
  localparam int unsigned NUM_SOURCES   = 8;

  // ----------------------------------------------------------------------
  // Reset values and mode thresholds.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPEN_FLAGS_RST  = 8'h00;
  localparam logic [7:0] OPEN_ENABLE_RST = 8'h00;
  localparam logic [7:0] OPEN_QUEUE_RST  = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
  localparam logic [5:0] SEL_RST         = 6'h00;
  localparam logic [7:0] MANUAL_QUEUE    = 8'h01;
  localparam logic [7:0] AUTO_QUEUE_MIN  = 8'h02;

  // ----------------------------------------------------------------------
  // Diagnostic source codes.
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_INPUT_PIN       = 3'h0;
  localparam logic [2:0] SRC_TEMP_SENSOR     = 3'h1;
  localparam logic [2:0] SRC_REFERENCE       = 3'h2;
  localparam logic [2:0] SRC_ANALOG_REG      = 3'h3;
  localparam logic [2:0] SRC_DIGITAL_REG     = 3'h4;
  localparam logic [2:0] SRC_IO_DRIVE_SUPPLY = 3'h5;
  localparam logic [2:0] SRC_ANALOG_GROUND   = 3'h6;
  localparam logic [2:0] SRC_ANALOG_SUPPLY   = 3'h7;

  // Byte address of a register index.
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

/* odmx_source_decode.sv */
// Registered decode of one channel's diagnostic source selector.
`timescale 1ns/10ps
`default_nettype none

module odmx_source_decode (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Selector code from the register bank.
  input  wire logic [2:0] sel_code,
  // Routing to the analog front end.
  output logic      [7:0] route_onehot,
  output logic            range_10v
);
  import odmx_pkg::*;

  logic [7:0] route_reg;
  logic [7:0] route_next;
  logic       range_reg;
  logic       range_next;

  // One-hot switch per source; any source but the pin forces the 10 V range.
  always_comb begin
    route_next = 8'h00;
    case (sel_code)
      SRC_INPUT_PIN:       route_next = 8'h01;
      SRC_TEMP_SENSOR:     route_next = 8'h02;
      SRC_REFERENCE:       route_next = 8'h04;
      SRC_ANALOG_REG:      route_next = 8'h08;
      SRC_DIGITAL_REG:     route_next = 8'h10;
      SRC_IO_DRIVE_SUPPLY: route_next = 8'h20;
      SRC_ANALOG_GROUND:   route_next = 8'h40;
      SRC_ANALOG_SUPPLY:   route_next = 8'h80;
      default:             route_next = 8'h01;
    endcase
    range_next = (sel_code != SRC_INPUT_PIN);
  end

  // Registers the routing so the outputs come from flip-flops.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      route_reg <= 8'h01;
      range_reg <= 1'b0;
    end else begin
      route_reg <= route_next;
      range_reg <= range_next;
    end
  end

  assign route_onehot = route_reg;
  assign range_10v    = range_reg;

  // Each code lands on exactly its own source switch one cycle later.
  source_route_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> route_reg == (8'h01 << $past(sel_code)))
    else $error("Source switch does not match the selector code.");

  // A diagnostic source runs in the 10 V range, the pin in its own range.
  range_force_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> range_reg == ($past(sel_code) != 3'h0))
    else $error("Range forcing does not follow the selector.");

endmodule

`default_nettype wire

/* odmx_front_end_model.sv */
// Behavioural model of the analog front end beside the register block.
`timescale 1ns/10ps
`default_nettype none

module odmx_front_end_model (
  // Clock.
  input  wire logic       sys_clk,
  // Common mode switch requests from the block.
  input  wire logic [7:0] cm_switch,
  // Conversion and open-circuit status toward the block.
  output logic            conv_done,
  output logic      [7:0] code_unchanged,
  output logic      [7:0] open_detect_event
);
  logic [7:0] cm_count = 8'h00;

  // The front end is quiet until the bench asks for activity.
  initial begin
    conv_done         = 1'b0;
    code_unchanged    = 8'h00;
    open_detect_event = 8'h00;
  end

  // Counts switch pulses on input 1 so the bench can compare totals.
  always @(posedge sys_clk) begin
    if (cm_switch[0] === 1'b1) begin
      cm_count <= cm_count + 8'h01;
    end
  end

  // Raises a one-cycle open-circuit pulse on the inputs in the mask.
  task automatic pulse_event(input logic [7:0] mask);
    open_detect_event <= mask;
    @(posedge sys_clk);
    open_detect_event <= 8'h00;
    @(posedge sys_clk);
  endtask

  // Runs conversions four cycles apart with the given unchanged flags.
  task automatic convert(input int n, input logic [7:0] same);
    repeat (n) begin
      conv_done      <= 1'b1;
      code_unchanged <= same;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the open flag and diagnostic source registers.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import odmx_pkg::*;

  logic             sys_clk;
  logic             reset;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             conv_done;
  logic [7:0]       code_unchanged;
  logic [7:0]       open_detect_event;
  logic [7:0]       cm_switch;
  logic [7:0]       pga_cm_high;
  logic [5:0][7:0]  chan_source_route;
  logic [5:0]       range_10v;
  logic             irq;
  logic [2:0]       hi;
  logic [2:0]       lo;
  logic [31:0]      d;
  logic             e;
  logic [7:0]       base;
  int               errors;
  int               total_checks;

  // The block under test and the front end model beside it.
  odmx_regs uut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .code_unchanged(code_unchanged), .open_detect_event(open_detect_event),
    .cm_switch(cm_switch), .pga_cm_high(pga_cm_high),
    .chan_source_route(chan_source_route), .range_10v(range_10v),
    .irq(irq)
  );
  odmx_front_end_model fe (
    .sys_clk(sys_clk), .cm_switch(cm_switch), .conv_done(conv_done),
    .code_unchanged(code_unchanged), .open_detect_event(open_detect_event)
  );

  // ----------------------------------------------------------------------
  // Clock, comparison and bus tasks.
  // ----------------------------------------------------------------------
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Counts every comparison and reports any mismatch at once.
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Registers sit one per word, so the byte address is four times the index.
  function automatic logic [7:0] adr(input logic [7:0] idx);
    adr = {idx[5:0], 2'b00};
  endfunction

  // One APB transfer, held until pready is sampled high or the bound runs out.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      errors++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register write by index.
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, adr(idx), wd, rd, err);
  endtask

  // Register read by index, compared with the expected word.
  task automatic rd(input string nm, input logic [7:0] idx,
                    input logic [31:0] exp);
    logic [31:0] rdat;
    logic        err;
    apb(1'b0, adr(idx), 32'h0, rdat, err);
    check(nm, rdat, exp);
  endtask

  // Prints the totals and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    final_report;
  end

  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial begin
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 6; k++) begin
      check("route at reset", 32'(chan_source_route[k]), 32'h01);
    end
    check("range at reset", 32'(range_10v), 32'h0);
    check("irq at reset", 32'(irq), 32'h0);
    rd("open flags", IDX_OPEN_FLAGS, 32'h0);
    for (int r = 0; r < 3; r++) begin
      rd("selector", IDX_SEL_CH1_CH2 + 8'(r), 32'h0);
    end
    // With a queue of zero neither mode runs: no common mode, no flags.
    wr(IDX_OPEN_ENABLE, 32'hFF);
    fe.pulse_event(8'hFF);
    check("idle common mode", 32'(pga_cm_high), 32'h0);
    rd("open flags", IDX_OPEN_FLAGS, 32'h0);
    $display("test reset done");
    // Every code in both fields of each pair, with reserved bits set.
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 8; c++) begin
        hi = 3'(c);
        lo = 3'(7 - c);
        wr(IDX_SEL_CH1_CH2 + 8'(r), {26'h3FFFFFF, hi, lo});
        rd("selector", IDX_SEL_CH1_CH2 + 8'(r), {26'h0, hi, lo});
        check("odd route", 32'(chan_source_route[2*r]), 32'(8'h01 << lo));
        check("even route", 32'(chan_source_route[2*r+1]), 32'(8'h01 << hi));
        check("odd range", 32'(range_10v[2*r]), 32'(lo != 3'h0));
        check("even range", 32'(range_10v[2*r+1]), 32'(hi != 3'h0));
      end
    end
    for (int r = 0; r < 3; r++) begin
      rd("selector kept", IDX_SEL_CH1_CH2 + 8'(r), 32'h38);
    end
    $display("test selectors done");
    // The pair of channels 7 and 8 is not mapped here, nor is a skewed address.
    apb(1'b1, adr(8'h2B), 32'h3F, d, e);
    check("unmapped write err", 32'(e), 32'h1);
    apb(1'b0, adr(8'h2B), 32'h0, d, e);
    check("unmapped data", d, 32'h0);
    check("unmapped err", 32'(e), 32'h1);
    apb(1'b0, 8'hA1, 32'h0, d, e);
    check("misaligned err", 32'(e), 32'h1);
    rd("selector kept", IDX_SEL_CH5_CH6, 32'h38);
    $display("test unmapped done");
    // Manual mode ignores events; enable bits drive the common mode.
    wr(IDX_OPEN_QUEUE, 32'h01);
    wr(IDX_OPEN_ENABLE, 32'hFF);
    fe.pulse_event(8'hFF);
    check("manual common mode", 32'(pga_cm_high), 32'hFF);
    rd("open flags", IDX_OPEN_FLAGS, 32'h0);
    wr(IDX_OPEN_QUEUE, 32'h02);
    wr(IDX_OPEN_ENABLE, 32'h7F);
    fe.pulse_event(8'h80);
    check("auto common mode", 32'(pga_cm_high), 32'h0);
    rd("open flags", IDX_OPEN_FLAGS, 32'h0);
    wr(IDX_OPEN_ENABLE, 32'hFF);
    fe.pulse_event(8'h80);
    rd("open flags", IDX_OPEN_FLAGS, 32'h80);
    fe.pulse_event(8'h01);
    rd("open flags", IDX_OPEN_FLAGS, 32'h81);
    check("irq masked", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 32'h01);
    repeat (2) @(posedge sys_clk);
    check("irq unmasked", 32'(irq), 32'h1);
    wr(IDX_OPEN_FLAGS, 32'h80);
    rd("open flags", IDX_OPEN_FLAGS, 32'h01);
    wr(IDX_OPEN_FLAGS, 32'h00);
    rd("open flags", IDX_OPEN_FLAGS, 32'h01);
    check("irq held", 32'(irq), 32'h1);
    wr(IDX_OPEN_FLAGS, 32'h01);
    rd("open flags", IDX_OPEN_FLAGS, 32'h0);
    repeat (2) @(posedge sys_clk);
    check("irq cleared", 32'(irq), 32'h0);
    $display("test open flags done");
    // Six unchanged conversions with a queue of three switch twice.
    wr(IDX_OPEN_QUEUE, 32'h03);
    wr(IDX_OPEN_ENABLE, 32'h01);
    base = fe.cm_count;
    fe.convert(6, 8'hFF);
    repeat (4) @(posedge sys_clk);
    check("switch count", 32'(8'(fe.cm_count - base)), 32'(6 / 3));
    $display("test common mode switch done");
    final_report;
  end
endmodule
`default_nettype wire
